/* acc_checker.sv */
// acc_checker: validates an attrib frame and holds the link settings.
// assumes receive framer on clk_sys; software on avalon-mm.
`timescale 1ns/100ps
module acc_checker
  import acc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic frame_start,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic frame_end,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic attrib_accept,
  output logic attrib_silent,
  output logic active,
  output logic [1:0] tx_rate,
  output logic [1:0] rx_rate,
  output logic [7:0] tr0_min,
  output logic [7:0] tr1_min,
  output logic [8:0] pcd_frame_max,
  output logic omit_sof,
  output logic omit_eof
);
  import acc_pkg::*;

  logic rst_s1, rst_n;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // every property below runs on clk_sys and sleeps in reset
  default clocking acc_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  acc_if fi ();
  acc_parser u_parser (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .frame_start(frame_start),
    .byte_valid(byte_valid),
    .byte_data(byte_data),
    .frame_end(frame_end),
    .fo(fi)
  );

  // tr decoding: the tag always keeps the slowest timing
  function automatic logic [1:0] acc_tr_code(input logic [1:0] c);
    return (c == ACC_TR_CODE_RFU) ? ACC_TR_CODE_DEF : c;
  endfunction

  function automatic logic [8:0] acc_fs_bytes(input logic [3:0] c);
    case (c)
      ACC_FS_256: return 9'h100;
      ACC_FS_128: return 9'h080;
      ACC_FS_96: return 9'h060;
      ACC_FS_64: return 9'h040;
      default: return 9'h000;
    endcase
  endfunction

  // registers
  logic [31:0] pupi, next_pupi;
  logic enable, next_enable;
  logic [7:0] cnt_ok, next_cnt_ok;
  logic [7:0] cnt_bad, next_cnt_bad;
  logic [7:0] last_p1, next_last_p1;
  logic rd_pend, next_rd_pend;
  logic [31:0] rdata, next_rdata;
  logic clr_active;

  // outputs state
  logic next_accept, next_silent, next_active;
  logic [1:0] next_tx, next_rx;
  logic [7:0] next_tr0, next_tr1;
  logic [8:0] next_fsmax;
  acc_state_t st, next_st;

  // decode of the held frame
  logic is_attrib, id_ok, rate_ok, fs_ok, p3_ok, p4_ok, frame_good;
  logic [1:0] tr0_code, tr1_code;
  logic [1:0] p2_tx, p2_rx;

  always_comb begin
    is_attrib = (fi.cmd == ACC_CMD_ATTRIB);
    id_ok = (fi.ident == pupi);
    p2_tx = fi.p2[ACC_P2_TX_LSB +: 2];
    p2_rx = fi.p2[ACC_P2_RX_LSB +: 2];
    rate_ok = (p2_tx == p2_rx) &&
              (p2_tx == ACC_RATE_106 || p2_tx == ACC_RATE_212);
    fs_ok = (acc_fs_bytes(fi.p2[ACC_P2_FS_LSB +: 4]) != 9'h000);
    p3_ok = (fi.p3 == ACC_PARAM3_OK);
    p4_ok = (fi.p4[3:0] == ACC_CID_NONE);
    tr0_code = acc_tr_code(fi.p1[ACC_P1_TR0_LSB +: 2]);
    tr1_code = acc_tr_code(fi.p1[ACC_P1_TR1_LSB +: 2]);
    frame_good = fi.crc_ok && fi.len_ok;
  end

  always_comb begin
    next_st = st;
    next_accept = 1'b0;
    next_silent = 1'b0;
    next_active = active;
    // a clear in the accepting cycle loses to the set
    if (clr_active) begin
      next_active = 1'b0;
    end
    next_tx = tx_rate;
    next_rx = rx_rate;
    next_tr0 = tr0_min;
    next_tr1 = tr1_min;
    next_fsmax = pcd_frame_max;
    next_cnt_ok = cnt_ok;
    next_cnt_bad = cnt_bad;
    next_last_p1 = last_p1;
    unique case (st)
      ACC_IDLE: begin
        if (frame_start && enable) begin
          next_st = ACC_RECV;
        end
      end
      ACC_RECV: begin
        if (fi.done) begin
          next_st = ACC_CHECK;
        end
      end
      ACC_CHECK: begin
        next_st = ACC_IDLE;
        if (!frame_good || !is_attrib) begin
          next_st = ACC_DROP;
        end else if (id_ok && rate_ok && fs_ok && p3_ok && p4_ok) begin
          next_accept = 1'b1;
          next_active = 1'b1;
          next_tx = p2_tx;
          next_rx = p2_rx;
          next_fsmax = acc_fs_bytes(fi.p2[ACC_P2_FS_LSB +: 4]);
          next_last_p1 = fi.p1;
          next_cnt_ok = cnt_ok + 8'h01;
          // code decoded but the floor is always kept
          next_tr0 = (tr0_code == ACC_TR_CODE_DEF) ? ACC_TR0_FLOOR
                                                   : ACC_TR0_FLOOR;
          next_tr1 = (tr1_code == ACC_TR_CODE_DEF) ? ACC_TR1_FLOOR
                                                   : ACC_TR1_FLOOR;
        end else begin
          next_silent = 1'b1;
          next_cnt_bad = cnt_bad + 8'h01;
        end
      end
      ACC_DROP: begin
        next_st = ACC_IDLE;
      end
    endcase
    if (frame_start && st != ACC_IDLE) begin
      next_st = enable ? ACC_RECV : ACC_IDLE;
    end
  end

  // avalon slave: one wait cycle on read, writes take at once
  always_comb begin
    next_pupi = pupi;
    next_enable = enable;
    clr_active = 1'b0;
    next_rd_pend = 1'b0;
    next_rdata = rdata;
    if (avs_write) begin
      unique case (avs_address)
        ACC_REG_CTRL: begin
          if (avs_byteenable[0]) begin
            next_enable = avs_writedata[0];
          end
          if (avs_byteenable[0] && avs_writedata[1]) begin
            clr_active = 1'b1;
          end
        end
        ACC_REG_PUPI: begin
          for (int b = 0; b < 4; b++) begin
            if (avs_byteenable[b]) begin
              next_pupi[8*b +: 8] = avs_writedata[8*b +: 8];
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (avs_read && !rd_pend) begin
      next_rd_pend = 1'b1;
      unique case (avs_address)
        ACC_REG_CTRL: next_rdata = {31'h0000_0000, enable};
        ACC_REG_STAT: next_rdata = {cnt_bad, cnt_ok, 13'h0000, st, active};
        ACC_REG_PUPI: next_rdata = pupi;
        ACC_REG_CFG: next_rdata = {last_p1, 1'b0, pcd_frame_max,
                                   2'b00, tx_rate, 2'b00, rx_rate, 6'h00};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= ACC_IDLE;
      attrib_accept <= 1'b0;
      attrib_silent <= 1'b0;
      active <= 1'b0;
      tx_rate <= ACC_RATE_106;
      rx_rate <= ACC_RATE_106;
      tr0_min <= ACC_TR0_FLOOR;
      tr1_min <= ACC_TR1_FLOOR;
      pcd_frame_max <= 9'h000;
      cnt_ok <= 8'h00;
      cnt_bad <= 8'h00;
      last_p1 <= 8'h00;
      pupi <= ACC_PUPI_RST;
      enable <= 1'b0;
      rd_pend <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
      attrib_accept <= next_accept;
      attrib_silent <= next_silent;
      active <= next_active;
      tx_rate <= next_tx;
      rx_rate <= next_rx;
      tr0_min <= next_tr0;
      tr1_min <= next_tr1;
      pcd_frame_max <= next_fsmax;
      cnt_ok <= next_cnt_ok;
      cnt_bad <= next_cnt_bad;
      last_p1 <= next_last_p1;
      pupi <= next_pupi;
      enable <= next_enable;
      rd_pend <= next_rd_pend;
      rdata <= next_rdata;
    end
  end

  assign avs_readdata = rdata;
  assign avs_waitrequest = avs_read && !rd_pend;
  // framing flags never follow param1 bits 3-2
  assign omit_sof = 1'b0;
  assign omit_eof = 1'b0;

  // assertions
  sequence acc_good_s;
    st == ACC_CHECK && frame_good && is_attrib && id_ok && rate_ok &&
      fs_ok && p3_ok && p4_ok;
  endsequence
  // a restart in the judging cycle makes the match vanish on purpose
  sequence acc_done_s;
    st == ACC_RECV && fi.done ##1 st == ACC_CHECK && !frame_start;
  endsequence

  // command, identifier, timing and sof/eof flags
  cmd_code_a: assert property (attrib_accept |->
    $past(fi.cmd) == ACC_CMD_ATTRIB)
    else $error("accept without attrib code");
  drop_quiet_a: assert property (st == ACC_CHECK && !is_attrib |=>
    !attrib_accept && !attrib_silent)
    else $error("pulse on a foreign command");
  accept_good_a: assert property (acc_good_s |=>
    attrib_accept && active)
    else $error("good frame not accepted");
  id_gate_a: assert property (st == ACC_CHECK && !id_ok |=>
    !attrib_accept)
    else $error("accept with foreign identifier");
  tr0_floor_a: assert property (tr0_min == ACC_TR0_FLOOR)
    else $error("tr0 below floor");
  tr1_floor_a: assert property (tr1_min == ACC_TR1_FLOOR)
    else $error("tr1 below floor");
  tr0_rfu_a: assert property (fi.p1[7:6] == ACC_TR_CODE_RFU |->
    tr0_code == ACC_TR_CODE_DEF)
    else $error("tr0 rfu not mapped");
  tr1_rfu_a: assert property (fi.p1[5:4] == ACC_TR_CODE_RFU |->
    tr1_code == ACC_TR_CODE_DEF)
    else $error("tr1 rfu not mapped");
  sof_eof_a: assert property (!omit_sof && !omit_eof)
    else $error("sof or eof omitted");

  // link parameters
  rate_eq_a: assert property (st == ACC_CHECK && p2_tx != p2_rx |=>
    !attrib_accept)
    else $error("accept with unequal rates");
  hold_cfg_a: assert property (!attrib_accept |->
    $stable({tx_rate, rx_rate, pcd_frame_max}))
    else $error("link settings moved without accept");
  frame_size_a: assert property (attrib_accept |->
    pcd_frame_max != 9'h000)
    else $error("accept with bad frame size");
  fs_gate_a: assert property (st == ACC_CHECK && !fs_ok |=>
    !attrib_accept)
    else $error("accept with unknown frame size code");
  param3_a: assert property (st == ACC_CHECK &&
    fi.p3 != ACC_PARAM3_OK |=> !attrib_accept)
    else $error("accept with bad param3");
  cid_none_a: assert property (st == ACC_CHECK &&
    fi.p4[3:0] != ACC_CID_NONE |=> !attrib_accept)
    else $error("accept with cid");

  // framing and frame flow
  crc_gate_a: assert property (st == ACC_CHECK && !fi.crc_ok |=>
    !attrib_accept && !attrib_silent)
    else $error("acted on bad crc frame");
  frame_flow_a: assert property (acc_done_s |=>
    attrib_accept || attrib_silent || st == ACC_DROP)
    else $error("finished frame not judged");
  pulse_excl_a: assert property (
    !(attrib_accept && attrib_silent))
    else $error("accept and silent together");
  clear_active_a: assert property (clr_active && st != ACC_CHECK |=>
    !active)
    else $error("active not cleared");

  // register bus
  rd_wait_a: assert property (avs_read && avs_waitrequest |=>
    !avs_waitrequest)
    else $error("read held more than one wait cycle");
  wr_nowait_a: assert property (avs_write && !avs_read |->
    !avs_waitrequest)
    else $error("write stalled");
endmodule

/* acc_checker_bench.sv */
// acc_checker_bench: corner and random attrib frames against the checker.
// assumes acc_reader as frame source and avalon-mm register access.
`timescale 1ns/100ps
module acc_checker_bench;
  import acc_pkg::*;
  logic clk_sys = 0;
  logic nrst = 0;
  logic [3:0] avs_address = 0;
  logic [3:0] avs_byteenable = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic avs_waitrequest, attrib_accept, attrib_silent, active;
  logic [1:0] tx_rate, rx_rate, e_rate;
  logic [7:0] tr0_min, tr1_min;
  logic [8:0] pcd_frame_max, e_max;
  logic omit_sof, omit_eof, frame_start, byte_valid, frame_end, e_act;
  logic [7:0] byte_data;
  logic [31:0] pupi = 32'h5a3c_96e1;
  int miscompares = 0;
  int n_tests = 0;
  int n_acc = 0;
  int n_sil = 0;
  int e_ok = 0;
  int e_bad = 0;
  bit en = 0;

  acc_checker DUT (.clk_sys(clk_sys), .nrst(nrst),
    .frame_start(frame_start), .byte_valid(byte_valid),
    .byte_data(byte_data), .frame_end(frame_end),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .attrib_accept(attrib_accept),
    .attrib_silent(attrib_silent), .active(active), .tx_rate(tx_rate),
    .rx_rate(rx_rate), .tr0_min(tr0_min), .tr1_min(tr1_min),
    .pcd_frame_max(pcd_frame_max), .omit_sof(omit_sof),
    .omit_eof(omit_eof));
  acc_reader rdr (.clk_sys(clk_sys), .frame_start(frame_start),
    .byte_valid(byte_valid), .byte_data(byte_data),
    .frame_end(frame_end));

  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (attrib_accept === 1'b1)
      n_acc++;
    if (attrib_silent === 1'b1)
      n_sil++;
  end

  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge
  task bus(input bit wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 50)
      miscompares++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // one idle edge so a following call never re-raises in this step
    @(posedge clk_sys);
  endtask
  function automatic logic [8:0] fs_of(input logic [3:0] c);
    case (c)
      4'h8: return 9'h100;
      4'h7: return 9'h080;
      4'h6: return 9'h060;
      default: return 9'h040;
    endcase
  endfunction
  function automatic int expect_of(input logic [7:0] c,
      input logic [31:0] id, input logic [7:0] p2, p3, p4);
    if (!en || c != ACC_CMD_ATTRIB)
      return 0;
    if (id != pupi || p2[7:6] != p2[5:4] || p2[7] || p3 != 8'h01)
      return 2;
    if (p4[3:0] != 4'h0 || !(p2[3:0] inside {[4'h5:4'h8]}))
      return 2;
    return 1;
  endfunction
  task frame(input logic [7:0] c, input logic [31:0] id,
      input logic [7:0] p1, p2, p3, p4, input bit bad);
    int a0, s0, ex;
    a0 = n_acc;
    s0 = n_sil;
    ex = bad ? 0 : expect_of(c, id, p2, p3, p4);
    e_ok += (ex == 1);
    e_bad += (ex == 2);
    rdr.send({p4, p3, p2, p1, id, c}, bad, $urandom_range(2));
    repeat (6) @(posedge clk_sys);
    if (ex == 1) begin
      e_rate = p2[7:6];
      e_max = fs_of(p2[3:0]);
      e_act = 1'b1;
    end
    chk(n_acc - a0, ex == 1);
    chk(n_sil - s0, ex == 2);
    chk({tx_rate, rx_rate, pcd_frame_max}, {e_rate, e_rate, e_max});
    chk({tr0_min, tr1_min}, {ACC_TR0_FLOOR, ACC_TR1_FLOOR});
    chk({omit_sof, omit_eof, active}, {2'b00, e_act});
  endtask

  initial begin
    repeat (50000) @(posedge clk_sys);
    miscompares++;
    summarize;
  end
  initial begin
    logic [31:0] r, s;
    void'($urandom(32'hf25e));
    e_rate = 2'b00;
    e_max = 9'd0;
    e_act = 1'b0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(0, ACC_REG_STAT, 0);
    chk(rd, 0);
    bus(0, 4'h2, 0);
    chk(rd, 0);
    frame(8'h1d, pupi, 8'h00, 8'h08, 8'h01, 8'h00, 0);
    bus(1, ACC_REG_PUPI, pupi);
    bus(1, ACC_REG_CTRL, 32'h0000_0001);
    en = 1;
    bus(0, ACC_REG_PUPI, 0);
    chk(rd, pupi);
    $display("test reset done");
    frame(8'h1d, pupi, 8'hff, 8'h08, 8'h01, 8'hf0, 0);
    frame(8'h1d, pupi, 8'h00, 8'h08, 8'h01, 8'h00, 1);
    frame(8'h1c, pupi, 8'h00, 8'h08, 8'h01, 8'h00, 0);
    frame(8'h1d, ~pupi, 8'h00, 8'h08, 8'h01, 8'h00, 0);
    frame(8'h1d, pupi, 8'h00, 8'h18, 8'h01, 8'h00, 0);
    frame(8'h1d, pupi, 8'h00, 8'ha8, 8'h01, 8'h00, 0);
    frame(8'h1d, pupi, 8'h00, 8'h09, 8'h01, 8'h00, 0);
    frame(8'h1d, pupi, 8'h00, 8'h04, 8'h01, 8'h00, 0);
    frame(8'h1d, pupi, 8'h00, 8'h08, 8'h11, 8'h00, 0);
    frame(8'h1d, pupi, 8'h00, 8'h08, 8'h01, 8'h01, 0);
    for (int k = 5; k < 9; k++)
      frame(8'h1d, pupi, 8'h50, {4'h5, 4'(k)}, 8'h01, 8'h00, 0);
    bus(1, ACC_REG_CTRL, 32'h0000_0003);
    e_act = 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(active, 0);
    bus(0, ACC_REG_STAT, 0);
    chk(rd, {e_bad[7:0], e_ok[7:0], 16'h0000});
    bus(0, ACC_REG_CFG, 0);
    chk(rd, {8'h50, 1'b0, e_max, 2'b00, e_rate, 2'b00,
      e_rate, 6'h00});
    $display("test corners done");
    for (int k = 0; k < 60; k++) begin
      r = $urandom;
      s = $urandom;
      if (r[11:9] != 3'b000)
        r[13:12] = {1'b0, r[8]};
      if (r[14])
        r[18:15] = 4'h5 + r[16:15];
      frame((r[3:0] == 4'h0) ? 8'h1c : 8'h1d, (r[7:4] == 4'h0) ? ~pupi :
        pupi, s[7:0], {1'b0, r[8], r[13:12], r[18:15]},
        (r[21:19] == 3'b000) ? r[29:22] : 8'h01,
        {s[11:8], s[14] ? s[15:12] : 4'h0}, s[19:16] == 4'h0);
    end
    $display("test random done");
    summarize;
  end
endmodule

/* acc_if.sv */
// acc_if: parsed frame fields between parser and checker.
// assumes one clock; all fields valid while done is high.
`timescale 1ns/100ps
interface acc_if;
  logic done;
  logic crc_ok;
  logic len_ok;
  logic [7:0] cmd;
  logic [31:0] ident;
  logic [7:0] p1;
  logic [7:0] p2;
  logic [7:0] p3;
  logic [7:0] p4;
  modport parser (output done, crc_ok, len_ok, cmd, ident, p1, p2, p3, p4);
  modport sink (input done, crc_ok, len_ok, cmd, ident, p1, p2, p3, p4);
endinterface

/* acc_parser.sv */
// acc_parser: collects frame bytes and runs the crc over them.
// assumes byte strobes from the receive framer on the same clock.
`timescale 1ns/100ps
module acc_parser
  import acc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic frame_start,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic frame_end,
  acc_if.parser fo
);
  logic [3:0] cnt, next_cnt;
  logic [15:0] crc, next_crc;
  logic [7:0] buf_q [0:8];
  logic [7:0] next_buf [0:8];
  logic done, next_done;
  logic over, next_over;

  function automatic logic [15:0] acc_crc_byte(input logic [15:0] c,
                                               input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ ACC_CRC_POLY_R) : (r >> 1);
    end
    return r;
  endfunction

  always_comb begin
    next_cnt = cnt;
    next_crc = crc;
    next_done = 1'b0;
    next_over = over;
    for (int i = 0; i < 9; i++) begin
      next_buf[i] = buf_q[i];
    end
    if (frame_start) begin
      next_cnt = 4'h0;
      next_crc = ACC_CRC_INIT;
      next_over = 1'b0;
    end else if (byte_valid) begin
      next_crc = acc_crc_byte(crc, byte_data);
      if (cnt < 4'd9) begin
        next_buf[cnt] = byte_data;
      end
      if (cnt == 4'hF) begin
        next_over = 1'b1;
      end else begin
        next_cnt = cnt + 4'h1;
      end
    end else if (frame_end) begin
      next_done = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      crc <= ACC_CRC_INIT;
      done <= 1'b0;
      over <= 1'b0;
      for (int i = 0; i < 9; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else begin
      cnt <= next_cnt;
      crc <= next_crc;
      done <= next_done;
      over <= next_over;
      for (int i = 0; i < 9; i++) begin
        buf_q[i] <= next_buf[i];
      end
    end
  end

  // residue of zero: crc bytes sent uncomplemented, low byte first
  assign fo.done = done;
  assign fo.crc_ok = (crc == 16'h0000);
  assign fo.len_ok = !over && (cnt == 4'(ACC_FRAME_LEN));
  assign fo.cmd = buf_q[0];
  assign fo.ident = {buf_q[4], buf_q[3], buf_q[2], buf_q[1]};
  assign fo.p1 = buf_q[5];
  assign fo.p2 = buf_q[6];
  assign fo.p3 = buf_q[7];
  assign fo.p4 = buf_q[8];
endmodule

/* acc_pkg.sv */
// acc_pkg: constants shared by the command checker and its byte parser.
// assumes a byte stream with frame start/end marks from the receive framer.
package acc_pkg;
  localparam logic [7:0] ACC_CMD_ATTRIB = 8'h1D;
  localparam logic [7:0] ACC_PARAM3_OK = 8'h01;
  localparam logic [3:0] ACC_CID_NONE = 4'h0;
  localparam logic [3:0] ACC_PROTO_TYPE = 4'h1;
  localparam logic [31:0] ACC_PUPI_RST = 32'h0000_0000;
  localparam int ACC_FRAME_LEN = 11;
  // param1 fields
  localparam int ACC_P1_TR0_LSB = 6;
  localparam int ACC_P1_TR1_LSB = 4;
  localparam int ACC_P1_EOF_BIT = 3;
  localparam int ACC_P1_SOF_BIT = 2;
  // param2 fields
  localparam int ACC_P2_TX_LSB = 6;
  localparam int ACC_P2_RX_LSB = 4;
  localparam int ACC_P2_FS_LSB = 0;
  localparam logic [1:0] ACC_RATE_106 = 2'h0;
  localparam logic [1:0] ACC_RATE_212 = 2'h1;
  localparam logic [1:0] ACC_TR_CODE_RFU = 2'h3;
  localparam logic [1:0] ACC_TR_CODE_DEF = 2'h0;
  localparam logic [3:0] ACC_FS_256 = 4'h8;
  localparam logic [3:0] ACC_FS_128 = 4'h7;
  localparam logic [3:0] ACC_FS_96 = 4'h6;
  localparam logic [3:0] ACC_FS_64 = 4'h5;
  // timings in 1/fs units
  localparam logic [7:0] ACC_TR0_FLOOR = 8'h40;
  localparam logic [7:0] ACC_TR1_FLOOR = 8'h50;
  localparam logic [15:0] ACC_CRC_INIT = 16'h6363;
  localparam logic [15:0] ACC_CRC_POLY_R = 16'h8408;
  // register map, byte addresses
  localparam logic [3:0] ACC_REG_CTRL = 4'h0;
  localparam logic [3:0] ACC_REG_STAT = 4'h4;
  localparam logic [3:0] ACC_REG_PUPI = 4'h8;
  localparam logic [3:0] ACC_REG_CFG = 4'hC;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_RECV = 2'b01,
    ACC_CHECK = 2'b11,
    ACC_DROP = 2'b10
  } acc_state_t;
endpackage

/* acc_reader.sv */
// acc_reader: reader-side frame source, appends crc_b to each frame.
// assumes the bench calls send right after a rising clock edge.
`timescale 1ns/100ps
module acc_reader
  import acc_pkg::*;
(
  input wire logic clk_sys,
  output logic frame_start,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic frame_end
);
  bit busy = 0;
  initial begin
    frame_start = 1'b0;
    byte_valid = 1'b0;
    frame_end = 1'b0;
    byte_data = 8'h00;
  end
  // idle data keeps flipping so nothing latches a stale byte by luck
  always @(posedge clk_sys) begin
    if (!busy)
      byte_data <= ~byte_data;
  end
  function automatic logic [15:0] crc_b(input logic [71:0] f);
    logic [15:0] c;
    c = ACC_CRC_INIT;
    for (int i = 0; i < 72; i++) begin
      if (c[0] ^ f[i])
        c = (c >> 1) ^ ACC_CRC_POLY_R;
      else
        c = c >> 1;
    end
    // sent uncomplemented so the receiver ends on a zero residue
    return c;
  endfunction
  // f holds bytes 0..8, byte 0 in bits 7:0; gap is idle cycles per byte
  task automatic send(input logic [71:0] f, input bit bad, input int gap);
    logic [87:0] all;
    all = {crc_b(f) ^ {15'h0000, bad}, f};
    busy = 1;
    frame_start <= 1'b1;
    @(posedge clk_sys);
    frame_start <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      byte_valid <= 1'b1;
      byte_data <= all[8*i +: 8];
      @(posedge clk_sys);
      if (gap > 0) begin
        byte_valid <= 1'b0;
        byte_data <= ~all[8*i +: 8];
        repeat (gap) @(posedge clk_sys);
      end
    end
    byte_valid <= 1'b0;
    frame_end <= 1'b1;
    @(posedge clk_sys);
    frame_end <= 1'b0;
    busy = 0;
  endtask
endmodule
